// File: hdl/roc_pkg.sv
package roc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_TMS = 8'h08;
    localparam logic [7:0] OFS_MIN_DLY = 8'h0C;
    localparam logic [7:0] OFS_DEF_DLY = 8'h10;
    localparam logic [7:0] OFS_RST_DLY = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_ELAPSED = 8'h24;
    localparam int SENS_BIT = 8;
    localparam int IRQ_START = 0;
    localparam int IRQ_TRIP = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Settings: limits and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] START_MIN = 16'd10;
    localparam logic [15:0] START_MIN_SENS = 16'd5;
    localparam logic [15:0] START_MAX = 16'd1000;
    localparam logic [9:0] START_DEF = 10'd50;
    localparam logic [15:0] TMS_MIN = 16'd5;
    localparam logic [15:0] TMS_MAX = 16'd1500;
    localparam logic [10:0] TMS_DEF = 11'd100;
    localparam logic [15:0] DLY_MIN = 16'd40;
    localparam logic [15:0] RST_MIN = 16'd60;
    localparam logic [15:0] DLY_MAX = 16'd60000;
    localparam logic [15:0] DLY_DEF = 16'd100;

    // ------------------------------------------------------------
    // Scaling and timing
    // ------------------------------------------------------------
    localparam logic [13:0] MAG_PER_PCT = 14'd10;
    localparam logic [7:0] RESET_RATIO_PCT = 8'd95;
    localparam logic [7:0] PCT_FULL = 8'd100;
    localparam logic [12:0] RATIO_ONE_Q8 = 13'd256;
    localparam logic [12:0] RATIO_MAX_Q8 = 13'd5120;
    localparam logic [31:0] Q16_ONE = 32'd65536;
    localparam logic [15:0] ALPHA_002_LN2_Q16 = 16'd908;
    localparam logic [3:0] LOG_BIAS = 4'd8;
    localparam logic [3:0] RATIO_TOP_BIT = 4'd12;
    localparam logic [63:0] TMS_US_PER_MS = 64'd100000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Operation select and curves
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_OFF = 4'h0, OP_DEF = 4'h1, OP_IEC_INV = 4'h2, OP_IEC_VINV = 4'h3,
        OP_IEC_EINV = 4'h4, OP_IEC_LINV = 4'h5, OP_ANSI_INV = 4'h6,
        OP_ANSI_MINV = 4'h7, OP_ANSI_VINV = 4'h8, OP_ANSI_EINV = 4'h9,
        OP_ANSI_LINV = 4'hA, OP_ANSI_LVINV = 4'hB, OP_ANSI_LEINV = 4'hC
    } oper_e;

    localparam logic [3:0] CURVES = 4'd11;
    localparam logic [1:0] ALPHA_002 = 2'd0;
    localparam logic [1:0] ALPHA_1 = 2'd1;
    localparam logic [1:0] ALPHA_2 = 2'd2;
    localparam logic [31:0] K_US [11] = '{140000, 13500000, 80000000, 120000000,
        8600, 51500, 19610000, 28200000, 86000, 28550000, 64070000};
    localparam logic [31:0] C_US [11] = '{0, 0, 0, 0,
        18500, 114000, 491000, 121700, 185000, 712000, 250000};
    localparam logic [1:0] ALPHA [11] = '{ALPHA_002, ALPHA_1, ALPHA_2, ALPHA_1,
        ALPHA_002, ALPHA_002, ALPHA_2, ALPHA_2, ALPHA_002, ALPHA_2, ALPHA_2};
    localparam logic [31:0] KR_US [11] = '{0, 0, 0, 0,
        460000, 4850000, 21600000, 29100000, 4600000, 13460000, 30000000};

endpackage

// File: hdl/curve_time_calc.sv
`timescale 1ns/10ps
module curve_time_calc
    import roc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Settings and measurement
    input wire logic [3:0] mode,
    input wire logic [15:0] mag,
    input wire logic [13:0] thr,
    input wire logic [10:0] tms,
    // Computed times in ms
    output logic [31:0] op_ms_q,
    output logic [31:0] rst_ms_q
);

    logic [3:0] idx;
    logic [23:0] ratio_raw;
    logic [12:0] ratio;
    logic [25:0] sq;
    logic [3:0] msb;
    logic [12:0] norm;
    logic [15:0] log_q8;
    logic [31:0] den;
    logic [31:0] rden;
    logic [63:0] op_us;
    logic [63:0] op_ms;
    logic [63:0] rst_ms;

    // ------------------------------------------------------------
    // Ratio G/Gs in Q8, clamped at twenty
    // ------------------------------------------------------------
    always_comb begin
        idx = mode - 4'(OP_IEC_INV);
        if (idx >= CURVES) begin
            idx = '0;
        end
        ratio_raw = {mag, 8'h00} / 24'(thr);
        ratio = (ratio_raw > 24'(RATIO_MAX_Q8)) ? RATIO_MAX_Q8 : ratio_raw[12:0];
        sq = 26'(ratio) * 26'(ratio);
        msb = '0;
        for (int i = 0; i < 13; i++) begin
            if (ratio[i]) begin
                msb = 4'(i);
            end
        end
        norm = ratio << (RATIO_TOP_BIT - msb);
        // Small-alpha curves use alpha*ln(r); under 3 % off up to the clamp
        log_q8 = {4'h0, 4'(msb - LOG_BIAS), norm[11:4]};
    end

    // ------------------------------------------------------------
    // Operate and reset times
    // ------------------------------------------------------------
    always_comb begin
        op_us = '0;
        unique case (ALPHA[idx])
            ALPHA_2: den = 32'(sq) - Q16_ONE;
            ALPHA_1: den = {11'h000, ratio, 8'h00} - Q16_ONE;
            default: den = 32'((32'(log_q8) * 32'(ALPHA_002_LN2_Q16)) >> 8);
        endcase
        rden = Q16_ONE - 32'(sq);
        if (ratio <= RATIO_ONE_Q8 || den == '0) begin
            op_ms = '1;
        end else begin
            op_us = (64'(K_US[idx]) * 64'(Q16_ONE)) / 64'(den) + 64'(C_US[idx]);
            op_ms = (op_us * 64'(tms)) / TMS_US_PER_MS;
        end
        if (ratio >= RATIO_ONE_Q8 || rden == '0) begin
            rst_ms = '1;
        end else begin
            rst_ms = (64'(KR_US[idx]) * 64'(Q16_ONE) * 64'(tms)) /
                     (64'(rden) * TMS_US_PER_MS);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            op_ms_q <= '1;
            rst_ms_q <= '1;
        end else begin
            op_ms_q <= (op_ms[63:32] != '0) ? '1 : op_ms[31:0];
            rst_ms_q <= (rst_ms[63:32] != '0) ? '1 : rst_ms[31:0];
        end
    end

endmodule // curve_time_calc

// File: hdl/residual_overcurrent_function.sv
`timescale 1ns/10ps
// How it works
// - Operation selects Off, definite time or one of eleven curves; Off after reset
// - Sole measurement is the residual current fundamental RMS magnitude
// - Inverse operate time scaled by time multiplier 0.05 to 15
// - Inverse curves also enforce a minimum delay of 40 to 60000 ms
// - Definite mode trips after its own delay, 40 to 60000 ms
// - IEC curves hold timing for a reset delay, 60 to 60000 ms
// - Internal trip only after the full operate delay while started
// - General start output follows the started state
// - General trip output formed from internal start and trip
// - Blocking input disables the function and its outputs
// - Inverse time is multiplier times k over ratio power alpha minus one, plus c
// - Ratio above twenty is treated as twenty
// - Inverse trip needs both curve time and minimum delay expired
// - IEC curves reset after fixed delay, ANSI curves after reset curve time
module residual_overcurrent_function
    import roc_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // Register bus
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Measurement and user logic
    input wire logic [15:0] RESIDUAL_CURRENT_MAGNITUDE,
    input wire logic BLOCK_IN,
    // Indications
    output logic GENERAL_START_OUT,
    output logic GENERAL_TRIP_OUT,
    output logic IRQ
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TIMING = 4'b0010,
        ST_TRIP = 4'b0100,
        ST_RESET = 4'b1000
    } stage_e;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[7:2] <= OFS_ELAPSED[7:2]);
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        strb_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                strb_merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction

    function automatic logic [15:0] clamp(input logic [31:0] v,
            input logic [15:0] lo, input logic [15:0] hi);
        if (v < 32'(lo)) begin
            clamp = lo;
        end else if (v > 32'(hi)) begin
            clamp = hi;
        end else begin
            clamp = v[15:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    oper_e oper_q;
    logic sens_q;
    logic [9:0] start_set_q;
    logic [10:0] tms_q;
    logic [15:0] min_dly_q;
    logic [15:0] def_dly_q;
    logic [15:0] rst_dly_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic aw_hold_q;
    logic w_hold_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic wr_go;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [16:0] tick_cnt_q;
    logic tick;
    logic enabled;
    logic inverse;
    logic ansi;
    logic [13:0] thr;
    logic pickup;
    logic dropout;
    logic start_q;
    stage_e stage_q;
    stage_e stage_d;
    logic [31:0] elapsed_q;
    logic [31:0] rcnt_q;
    logic [31:0] op_ms;
    logic [31:0] rst_ms;
    logic op_due;
    logic rst_due;
    logic gen_start_d;
    logic gen_trip_d;
    logic gen_start_q;
    logic gen_trip_q;

    function automatic logic [31:0] reg_value(input logic [7:0] a);
        reg_value = '0;
        if (reg_hit(a, OFS_CONTROL)) begin
            reg_value = {23'h0, sens_q, 4'h0, oper_q};
        end else if (reg_hit(a, OFS_START)) begin
            reg_value = {22'h0, start_set_q};
        end else if (reg_hit(a, OFS_TMS)) begin
            reg_value = {21'h0, tms_q};
        end else if (reg_hit(a, OFS_MIN_DLY)) begin
            reg_value = {16'h0, min_dly_q};
        end else if (reg_hit(a, OFS_DEF_DLY)) begin
            reg_value = {16'h0, def_dly_q};
        end else if (reg_hit(a, OFS_RST_DLY)) begin
            reg_value = {16'h0, rst_dly_q};
        end else if (reg_hit(a, OFS_STATUS)) begin
            reg_value = {28'h0, stage_q == ST_RESET, BLOCK_IN, gen_trip_q, gen_start_q};
        end else if (reg_hit(a, OFS_IRQ_STAT)) begin
            reg_value = {30'h0, irq_stat_q};
        end else if (reg_hit(a, OFS_IRQ_MASK)) begin
            reg_value = {30'h0, irq_mask_q};
        end else if (reg_hit(a, OFS_ELAPSED)) begin
            reg_value = elapsed_q;
        end
    endfunction

    // ------------------------------------------------------------
    // Register bus: write path
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
    assign S_AXI_WREADY = !w_hold_q && !bvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

    always_comb begin
        wr_word = strb_merge(reg_value(awaddr_q), wdata_q, wstrb_q);
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            aw_hold_q <= 1'h0;
            w_hold_q <= 1'h0;
            bvalid_q <= 1'h0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'h1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'h1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_hold_q <= 1'h0;
                w_hold_q <= 1'h0;
                bvalid_q <= 1'h1;
                bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'h0;
            end
        end
    end

    // Settings are clamped into their legal range on write
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            oper_q <= OP_OFF;
            sens_q <= 1'h0;
            start_set_q <= START_DEF;
            tms_q <= TMS_DEF;
            min_dly_q <= DLY_DEF;
            def_dly_q <= DLY_DEF;
            rst_dly_q <= DLY_DEF;
            irq_mask_q <= '0;
        end else if (wr_go) begin
            if (reg_hit(awaddr_q, OFS_CONTROL)) begin
                oper_q <= (wr_word[3:0] > OP_ANSI_LEINV) ? OP_OFF : oper_e'(wr_word[3:0]);
                sens_q <= wr_word[SENS_BIT];
            end
            if (reg_hit(awaddr_q, OFS_START)) begin
                start_set_q <= 10'(clamp(wr_word, sens_q ? START_MIN_SENS : START_MIN,
                                          START_MAX));
            end
            if (reg_hit(awaddr_q, OFS_TMS)) begin
                tms_q <= 11'(clamp(wr_word, TMS_MIN, TMS_MAX));
            end
            if (reg_hit(awaddr_q, OFS_MIN_DLY)) begin
                min_dly_q <= clamp(wr_word, DLY_MIN, DLY_MAX);
            end
            if (reg_hit(awaddr_q, OFS_DEF_DLY)) begin
                def_dly_q <= clamp(wr_word, DLY_MIN, DLY_MAX);
            end
            if (reg_hit(awaddr_q, OFS_RST_DLY)) begin
                rst_dly_q <= clamp(wr_word, RST_MIN, DLY_MAX);
            end
            if (reg_hit(awaddr_q, OFS_IRQ_MASK)) begin
                irq_mask_q <= wr_word[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Register bus: read path
    // ------------------------------------------------------------
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    always_comb begin
        rd_word = reg_value(S_AXI_ARADDR);
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rvalid_q <= 1'h0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_q <= 1'h1;
            rdata_q <= rd_word;
            rresp_q <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    assign tick = (tick_cnt_q == 17'(CYCLES_PER_MS - 1));

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 17'h00001;
        end
    end

    // ------------------------------------------------------------
    // Start detection with 95 % drop-off
    // ------------------------------------------------------------
    assign enabled = (oper_q != OP_OFF) && !BLOCK_IN;
    assign inverse = (oper_q >= OP_IEC_INV);
    assign ansi = (oper_q >= OP_ANSI_INV);
    assign thr = 14'(start_set_q) * MAG_PER_PCT;
    assign pickup = RESIDUAL_CURRENT_MAGNITUDE > 16'(thr);
    // Hysteresis stops chatter on a magnitude that sits at the threshold
    assign dropout = (24'(RESIDUAL_CURRENT_MAGNITUDE) * 24'(PCT_FULL)) <
                     (24'(thr) * 24'(RESET_RATIO_PCT));

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            start_q <= 1'h0;
        end else if (!enabled) begin
            start_q <= 1'h0;
        end else if (pickup) begin
            start_q <= 1'h1;
        end else if (dropout) begin
            start_q <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Characteristic timing
    // ------------------------------------------------------------
    curve_time_calc curve_time_calc_i (
        .clock(CLOCK),
        .reset(RESET),
        .mode(oper_q),
        .mag(RESIDUAL_CURRENT_MAGNITUDE),
        .thr(thr),
        .tms(tms_q),
        .op_ms_q(op_ms),
        .rst_ms_q(rst_ms)
    );

    assign op_due = inverse ? (elapsed_q >= op_ms && elapsed_q >= 32'(min_dly_q))
                            : (elapsed_q >= 32'(def_dly_q));
    assign rst_due = rcnt_q >= (ansi ? rst_ms : 32'(rst_dly_q));

    always_comb begin
        stage_d = stage_q;
        unique case (stage_q)
            ST_IDLE: begin
                if (start_q) begin
                    stage_d = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!start_q) begin
                    stage_d = inverse ? ST_RESET : ST_IDLE;
                end else if (op_due) begin
                    stage_d = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (!start_q) begin
                    stage_d = inverse ? ST_RESET : ST_IDLE;
                end
            end
            ST_RESET: begin
                if (start_q) begin
                    stage_d = ST_TIMING;
                end else if (rst_due) begin
                    stage_d = ST_IDLE;
                end
            end
            default: stage_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            stage_q <= ST_IDLE;
        end else begin
            stage_q <= enabled ? stage_d : ST_IDLE;
        end
    end

    // In inverse modes elapsed time survives a short dip so a repeat fault trips sooner; definite mode clears it
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            elapsed_q <= '0;
        end else if (!enabled || stage_q == ST_IDLE) begin
            elapsed_q <= '0;
        end else if (tick && stage_q != ST_RESET && elapsed_q != '1) begin
            elapsed_q <= elapsed_q + 32'h00000001;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            rcnt_q <= '0;
        end else if (stage_q != ST_RESET) begin
            rcnt_q <= '0;
        end else if (tick && rcnt_q != '1) begin
            rcnt_q <= rcnt_q + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // Decision logic and interrupt
    // ------------------------------------------------------------
    assign gen_start_d = enabled && start_q;
    assign gen_trip_d = enabled && start_q && stage_q == ST_TRIP;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            gen_start_q <= 1'h0;
            gen_trip_q <= 1'h0;
        end else begin
            gen_start_q <= gen_start_d;
            gen_trip_q <= gen_trip_d;
        end
    end

    // A rising edge arriving with a clear write still sets the bit
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q[IRQ_START] <= (irq_stat_q[IRQ_START] &&
                !(wr_go && reg_hit(awaddr_q, OFS_IRQ_STAT) && wr_word[IRQ_START])) ||
                (gen_start_d && !gen_start_q);
            irq_stat_q[IRQ_TRIP] <= (irq_stat_q[IRQ_TRIP] &&
                !(wr_go && reg_hit(awaddr_q, OFS_IRQ_STAT) && wr_word[IRQ_TRIP])) ||
                (gen_trip_d && !gen_trip_q);
        end
    end

    assign GENERAL_START_OUT = gen_start_q;
    assign GENERAL_TRIP_OUT = gen_trip_q;
    assign IRQ = |(irq_stat_q & irq_mask_q);

endmodule // residual_overcurrent_function

// File: sim/meas_model.sv
`timescale 1ns/10ps
module meas_model (
    // Clock and stimulus
    input logic clock,
    input logic [15:0] level,
    input logic hold_off,
    // Toward the function
    output logic [15:0] mag,
    output logic blk
);
    // Front end lags one clock
    initial {mag, blk} = '0;
    always @(posedge clock) begin
        mag <= level;
        blk <= hold_off;
    end
endmodule // meas_model

// File: sim/roc_checker.sv
`timescale 1ns/10ps
module roc_checker #(
    parameter int CYCLES_PER_MS = 10
) (
    // Clock and reset
    input logic CLOCK, RESET,
    // Register bus
    input logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
    input logic S_AXI_RVALID, S_AXI_RREADY,
    input logic [1:0] S_AXI_BRESP,
    input logic [31:0] S_AXI_RDATA,
    // Protection
    input logic BLOCK_IN, GENERAL_START_OUT, GENERAL_TRIP_OUT
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // First ms tick may come early
    logic [31:0] run_q;
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) run_q <= '0;
        else run_q <= GENERAL_START_OUT ? run_q + 32'h1 : '0;
    end
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    a_write_answer: assert property (wr_taken |=> ##[0:1] S_AXI_BVALID)
        else $error("write not answered");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped");
    a_bus_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answer pending");
    a_block_quiet: assert property (BLOCK_IN [*3] |-> !GENERAL_START_OUT && !GENERAL_TRIP_OUT)
        else $error("output active while blocked");
    a_trip_start: assert property (GENERAL_TRIP_OUT |-> GENERAL_START_OUT)
        else $error("trip without start");
    a_trip_delay: assert property ($rose(GENERAL_TRIP_OUT) |-> run_q >= 38 * CYCLES_PER_MS)
        else $error("trip too early");
endmodule // roc_checker

// File: sim/residual_overcurrent_function_tb_top.sv
`timescale 1ns/10ps
module residual_overcurrent_function_tb_top;
    import roc_pkg::*;
    localparam int CPM = 10;
    logic clock = '0, reset = '1, awvalid = '0, wvalid = '0, bready = '0;
    logic arvalid = '0, rready = '0, blk_req = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [15:0] level = '0, mag;
    logic awready, wready, bvalid, arready, rvalid, blk, gstart, gtrip, irq;
    logic [1:0] bresp, rresp;
    int error_cnt = 0, check_count = 0;
    always #4 clock = ~clock;
    residual_overcurrent_function #(.CYCLES_PER_MS(CPM)) residual_overcurrent_function_i (
        .CLOCK(clock), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .RESIDUAL_CURRENT_MAGNITUDE(mag), .BLOCK_IN(blk), .GENERAL_START_OUT(gstart),
        .GENERAL_TRIP_OUT(gtrip), .IRQ(irq));
    meas_model meas_model_i (.clock(clock), .level(level), .hold_off(blk_req), .mag(mag), .blk(blk));
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do @(negedge clock); while (!(awready && wready));
        @(posedge clock);
        {awvalid, wvalid} <= 2'h0;
        do @(negedge clock); while (bvalid !== 1'b1);
        chk(bresp, r);
        @(posedge clock);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(negedge clock); while (arready !== 1'b1);
        @(posedge clock);
        arvalid <= 1'b0;
        do @(negedge clock); while (rvalid !== 1'b1);
        chk(rdata, e);
        chk(rresp, r);
        @(posedge clock);
        rready <= 1'b0;
    endtask
    // Window includes pickup latency
    task meas(input logic [15:0] v, input int lo, input int hi);
        int n;
        n = 0;
        level <= v;
        while (gtrip !== 1'b1) begin
            @(negedge clock);
            n++;
        end
        chk(n >= lo * CPM && n <= hi * CPM, 1'b1);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd(OFS_CONTROL, 32'h0);
        rd(OFS_START, 32'h32);
        rd(OFS_TMS, 32'h64);
        rd(OFS_MIN_DLY, 32'h64);
        rd(OFS_RST_DLY, 32'h64);
        rd(8'h28, 32'h0, RESP_SLVERR);
        wr(8'h28, 32'h1, RESP_SLVERR);
        for (int i = 0; i < 14; i++) begin
            wr(OFS_CONTROL, i);
            rd(OFS_CONTROL, i < 13 ? i : 0);
        end
        $display("test defaults done");
        wr(OFS_START, 32'h1);
        rd(OFS_START, 32'hA);
        wr(OFS_START, 32'h32);
        wr(OFS_TMS, 32'h7D0);
        rd(OFS_TMS, 32'h5DC);
        wr(OFS_TMS, 32'h64);
        wr(OFS_RST_DLY, 32'h0);
        rd(OFS_RST_DLY, 32'h3C);
        wr(OFS_DEF_DLY, 32'hA);
        rd(OFS_DEF_DLY, 32'h28);
        $display("test clamps done");
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_CONTROL, OP_DEF);
        meas(16'h258, 39, 41);
        chk({gstart, irq}, 2'h3);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_IRQ_STAT, 32'h3);
        chk(irq, 1'b0);
        blk_req <= 1'b1;
        repeat (4) @(negedge clock);
        chk({gstart, gtrip}, 2'h0);
        rd(OFS_STATUS, 32'h4);
        blk_req <= 1'b0;
        $display("test definite done");
        wr(OFS_CONTROL, OP_OFF);
        level <= '0;
        repeat (3) @(negedge clock);
        chk({gstart, gtrip}, 2'h0);
        wr(OFS_CONTROL, OP_IEC_EINV);
        meas(16'h3A98, 194, 207);
        level <= '0;
        repeat (3) @(negedge clock);
        rd(OFS_STATUS, 32'h8);
        $display("test inverse done");
        final_report;
    end
endmodule // residual_overcurrent_function_tb_top
bind residual_overcurrent_function roc_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) roc_checker_i (
    .CLOCK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
    .S_AXI_RREADY, .S_AXI_BRESP, .S_AXI_RDATA, .BLOCK_IN, .GENERAL_START_OUT,
    .GENERAL_TRIP_OUT);
